/* logic/cpr_defines.vh */
/*
 Constants for the core programmer-visible register block: memory-mapped
 offsets, field positions, reset values, operation codes and stack layout.
 Assumes it is included once by bare name by each file that needs it.
*/
//==============================================================
//==============================================================
`ifndef CPR_DEFINES_VH
`define CPR_DEFINES_VH

// memory-mapped offsets
`define CPR_ADDR_XHI      8'hBE
`define CPR_ADDR_XLO      8'hBF
`define CPR_ADDR_STK      8'hCE
`define CPR_ADDR_FLAGS    8'hCF

// flags register fields
`define CPR_F_READY       7
`define CPR_F_GIE         4
`define CPR_F_ZERO        3
`define CPR_F_CARRY       2
`define CPR_F_HALF        1
`define CPR_F_NEG         0

// index-pointer high byte fields
`define CPR_XHI_SPACE     2
`define CPR_XHI_TOP       1

// reset values and fixed address parts
`define CPR_PC_RESET      10'h000
`define CPR_CODE_BASE     2'h3
`define CPR_DATA_BASE     2'h0
`define CPR_STK_RESET     4'hF
`define CPR_STK_BASE      4'h3
`define CPR_STK_STEP      4'h2
`define CPR_STK_ONE       4'h1

// operation codes from the sequencer
`define CPR_OP_NOP        5'h00
`define CPR_OP_ADD        5'h01
`define CPR_OP_ADDC       5'h02
`define CPR_OP_SUBC       5'h03
`define CPR_OP_AND        5'h04
`define CPR_OP_OR         5'h05
`define CPR_OP_XOR        5'h06
`define CPR_OP_LDA        5'h07
`define CPR_OP_INC        5'h08
`define CPR_OP_DEC        5'h09
`define CPR_OP_CLR        5'h0A
`define CPR_OP_RLC        5'h0B
`define CPR_OP_RRC        5'h0C
`define CPR_OP_SC         5'h0D
`define CPR_OP_RC         5'h0E
`define CPR_OP_CARRY_INVERT       5'h0F
`define CPR_OP_LDC        5'h10
`define CPR_OP_LDX        5'h11
`define CPR_OP_JMP        5'h12
`define CPR_OP_CALL       5'h13
`define CPR_OP_RET        5'h14
`define CPR_OP_INTERRUPT_EXIT       5'h15
`define CPR_OP_SOFTWARE_TRAP       5'h16
`define CPR_OP_SETG       5'h17

`endif

/* logic/cpr_core_regs.v */
/*
 Programmer-visible registers of the 8-bit core: accumulator, index pointer,
 program counter, stack index, condition flags and interrupt priority pick.
 Assumes an instruction sequencer that issues one operation per cycle while
 busy is low, an SRAM with one-cycle read latency for the return stack, and
 a load/store path that reaches the mapped registers by address.
*/
`timescale 1ns/1ps
`include "cpr_defines.vh"

module cpr_core_regs (
	// clock and reset
	input  wire        clk,
	input  wire        rst,
	// operation port from the sequencer
	input  wire        opValid,
	input  wire [4:0]  opCode,
	input  wire [7:0]  opData,
	input  wire [10:0] opAddr,
	input  wire        pcStep,
	input  wire [7:0]  idxOffset,
	// memory-mapped load/store port
	input  wire        memWrEn,
	input  wire        memRdEn,
	input  wire [7:0]  memAddr,
	input  wire [7:0]  memWrData,
	output reg  [7:0]  memRdData_r,
	output reg         memHit_r,
	// return stack memory port
	output reg         stkWrEn_r,
	output reg         stkRdEn_r,
	output reg  [7:0]  stkAddr_r,
	output reg  [7:0]  stkWrData_r,
	input  wire [7:0]  stkRdData,
	// interrupt sources and status
	input  wire [4:0]  irqPending,
	input  wire        eeReady,
	output reg         intRequest_r,
	output reg  [2:0]  intLevel_r,
	// register views
	output reg  [7:0]  acc_r,
	output reg  [11:0] nextInstrAddr_r,
	output reg  [11:0] effAddr_r,
	output reg  [7:0]  flags_r,
	output reg  [3:0]  stackIndex_r,
	output reg         busy_r
);

	//==============================================================
	// stack sequencer states
	localparam ST_IDLE = 3'b000;
	localparam ST_PUSH = 3'b001;
	localparam ST_POP1 = 3'b010;
	localparam ST_POP2 = 3'b011;
	localparam ST_POP3 = 3'b100;

	//==============================================================
	// state
	reg  [2:0] state_r;
	reg  [2:0] state_nxt;
	reg  [9:0] pc_r;
	reg  [9:0] target_r;
	reg        xSpace_r;
	reg  [9:0] xLow_r;
	reg        isIntr_r;
	reg        isReti_r;
	reg  [7:0] popHi_r;

	// alu scratch
	reg  [7:0] aluB;
	reg        aluCin;
	reg  [8:0] aluSum;
	reg  [4:0] aluNib;
	reg  [7:0] res;
	reg        resValid;
	reg        carryNew;
	reg        halfNew;
	reg        carryWr;
	reg        halfWr;

	wire       opGo;
	wire [9:0] idxSum;
	wire [7:0] stkHere;
	wire [7:0] stkBelow;
	wire [7:0] stkAbove1;
	wire [7:0] stkAbove2;

	assign opGo      = opValid & (state_r == ST_IDLE);
	// only the ten location bits take part in the sum; the space bit stays separate
	assign idxSum    = xLow_r + {2'b00, idxOffset};
	// physical stack address is the fixed page plus the index; wrap is software's problem
	assign stkHere   = {`CPR_STK_BASE, stackIndex_r};
	assign stkBelow  = {`CPR_STK_BASE, stackIndex_r - `CPR_STK_ONE};
	assign stkAbove1 = {`CPR_STK_BASE, stackIndex_r + `CPR_STK_ONE};
	assign stkAbove2 = {`CPR_STK_BASE, stackIndex_r + `CPR_STK_STEP};

	//==============================================================
	// alu: result and carry terms for the current operation
	always @* begin
		aluB     = opData;
		aluCin   = 1'b0;
		res      = acc_r;
		resValid = 1'b0;
		carryNew = flags_r[`CPR_F_CARRY];
		halfNew  = flags_r[`CPR_F_HALF];
		carryWr  = 1'b0;
		halfWr   = 1'b0;
		if (opCode == `CPR_OP_SUBC) begin
			aluB = ~opData;
		end
		if (opCode == `CPR_OP_ADDC || opCode == `CPR_OP_SUBC) begin
			aluCin = flags_r[`CPR_F_CARRY];
		end
		aluSum = {1'b0, acc_r} + {1'b0, aluB} + {8'h00, aluCin};
		aluNib = {1'b0, acc_r[3:0]} + {1'b0, aluB[3:0]} + {4'h0, aluCin};
		case (opCode)
			`CPR_OP_ADD, `CPR_OP_ADDC, `CPR_OP_SUBC: begin
				res      = aluSum[7:0];
				resValid = 1'b1;
				carryNew = aluSum[8];
				halfNew  = aluNib[4];
				carryWr  = 1'b1;
				halfWr   = 1'b1;
			end
			`CPR_OP_AND: begin
				res      = acc_r & opData;
				resValid = 1'b1;
			end
			`CPR_OP_OR: begin
				res      = acc_r | opData;
				resValid = 1'b1;
			end
			`CPR_OP_XOR: begin
				res      = acc_r ^ opData;
				resValid = 1'b1;
			end
			`CPR_OP_LDA: begin
				res      = opData;
				resValid = 1'b1;
			end
			`CPR_OP_INC: begin
				res      = acc_r + 8'h01;
				resValid = 1'b1;
			end
			`CPR_OP_DEC: begin
				res      = acc_r - 8'h01;
				resValid = 1'b1;
			end
			`CPR_OP_CLR: begin
				res      = 8'h00;
				resValid = 1'b1;
			end
			`CPR_OP_RLC: begin
				res      = {acc_r[6:0], flags_r[`CPR_F_CARRY]};
				resValid = 1'b1;
				carryNew = acc_r[7];
				carryWr  = 1'b1;
			end
			`CPR_OP_RRC: begin
				res      = {flags_r[`CPR_F_CARRY], acc_r[7:1]};
				resValid = 1'b1;
				carryNew = acc_r[0];
				carryWr  = 1'b1;
			end
			`CPR_OP_SC: begin
				carryNew = 1'b1;
				halfNew  = 1'b1;
				carryWr  = 1'b1;
				halfWr   = 1'b1;
			end
			`CPR_OP_RC: begin
				carryNew = 1'b0;
				halfNew  = 1'b0;
				carryWr  = 1'b1;
				halfWr   = 1'b1;
			end
			`CPR_OP_CARRY_INVERT: begin
				carryNew = ~flags_r[`CPR_F_CARRY];
				carryWr  = 1'b1;
			end
			`CPR_OP_LDC: begin
				carryNew = opData[0];
				carryWr  = 1'b1;
			end
			default: begin
				res      = acc_r;
			end
		endcase
	end

	//==============================================================
	// stack sequencer next state
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (opGo && (opCode == `CPR_OP_CALL || opCode == `CPR_OP_SOFTWARE_TRAP)) begin
					state_nxt = ST_PUSH;
				end else if (opGo && (opCode == `CPR_OP_RET || opCode == `CPR_OP_INTERRUPT_EXIT)) begin
					state_nxt = ST_POP1;
				end
			end
			ST_PUSH: state_nxt = ST_IDLE;
			ST_POP1: state_nxt = ST_POP2;
			ST_POP2: state_nxt = ST_POP3;
			ST_POP3: state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	//==============================================================
	// accumulator, flags and index pointer
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_r    <= 8'h00;
			flags_r  <= 8'h00;
			xSpace_r <= 1'b0;
			xLow_r   <= 10'h000;
		end else begin
			// ready mirrors the eeprom; the two unused bits stay zero
			flags_r[`CPR_F_READY] <= eeReady;
			if (opGo && resValid) begin
				acc_r                <= res;
				flags_r[`CPR_F_ZERO] <= (res == 8'h00);
				flags_r[`CPR_F_NEG]  <= res[7];
			end
			if (opGo && carryWr) begin
				flags_r[`CPR_F_CARRY] <= carryNew;
			end
			if (opGo && halfWr) begin
				flags_r[`CPR_F_HALF] <= halfNew;
			end
			if (opGo && opCode == `CPR_OP_SETG) begin
				flags_r[`CPR_F_GIE] <= 1'b1;
			end
			if (opGo && opCode == `CPR_OP_LDX) begin
				xSpace_r <= opAddr[10];
				xLow_r   <= opAddr[9:0];
			end
			// mapped stores act after the sequencer op, so a store wins a same-cycle clash;
			// only the mask bit of the flags register can be stored this way
			if (memWrEn) begin
				if (memAddr == `CPR_ADDR_XHI) begin
					xSpace_r     <= memWrData[`CPR_XHI_SPACE];
					xLow_r[9:8]  <= memWrData[`CPR_XHI_TOP:0];
				end else if (memAddr == `CPR_ADDR_XLO) begin
					xLow_r[7:0]  <= memWrData;
				end else if (memAddr == `CPR_ADDR_FLAGS) begin
					flags_r[`CPR_F_GIE] <= memWrData[`CPR_F_GIE];
				end
			end
			// mask is cleared only once the counter is stacked and the vector taken
			if (state_r == ST_PUSH && isIntr_r) begin
				flags_r[`CPR_F_GIE] <= 1'b0;
			end
			if (state_r == ST_POP3 && isReti_r) begin
				flags_r[`CPR_F_GIE] <= 1'b1;
			end
		end
	end

	//==============================================================
	// program counter, stack index and stack memory sequencing
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r      <= ST_IDLE;
			pc_r         <= `CPR_PC_RESET;
			target_r     <= 10'h000;
			stackIndex_r <= `CPR_STK_RESET;
			isIntr_r     <= 1'b0;
			isReti_r     <= 1'b0;
			popHi_r      <= 8'h00;
			stkWrEn_r    <= 1'b0;
			stkRdEn_r    <= 1'b0;
			stkAddr_r    <= 8'h00;
			stkWrData_r  <= 8'h00;
		end else begin
			state_r   <= state_nxt;
			stkWrEn_r <= 1'b0;
			stkRdEn_r <= 1'b0;
			if (state_r == ST_IDLE && pcStep) begin
				pc_r <= pc_r + 10'h001;
			end
			if (memWrEn && memAddr == `CPR_ADDR_STK) begin
				stackIndex_r <= memWrData[3:0];
			end
			case (state_r)
				ST_IDLE: begin
					if (opGo && opCode == `CPR_OP_JMP) begin
						pc_r <= opAddr[9:0];
					end
					// low byte goes out first at the free slot
					if (opGo && (opCode == `CPR_OP_CALL || opCode == `CPR_OP_SOFTWARE_TRAP)) begin
						target_r    <= opAddr[9:0];
						isIntr_r    <= (opCode == `CPR_OP_SOFTWARE_TRAP);
						stkWrEn_r   <= 1'b1;
						stkAddr_r   <= stkHere;
						stkWrData_r <= pc_r[7:0];
					end
					if (opGo && (opCode == `CPR_OP_RET || opCode == `CPR_OP_INTERRUPT_EXIT)) begin
						isReti_r  <= (opCode == `CPR_OP_INTERRUPT_EXIT);
						stkRdEn_r <= 1'b1;
						stkAddr_r <= stkAbove1;
					end
				end
				ST_PUSH: begin
					stkWrEn_r    <= 1'b1;
					stkAddr_r    <= stkBelow;
					stkWrData_r  <= {6'h00, pc_r[9:8]};
					stackIndex_r <= stackIndex_r - `CPR_STK_STEP;
					pc_r         <= target_r;
				end
				ST_POP1: begin
					stkRdEn_r <= 1'b1;
					stkAddr_r <= stkAbove2;
				end
				ST_POP2: begin
					popHi_r <= stkRdData;
				end
				ST_POP3: begin
					pc_r         <= {popHi_r[1:0], stkRdData};
					stackIndex_r <= stackIndex_r + `CPR_STK_STEP;
				end
				default: begin
					pc_r <= pc_r;
				end
			endcase
		end
	end

	//==============================================================
	// visible views, mapped reads and interrupt pick
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			nextInstrAddr_r <= {`CPR_CODE_BASE, `CPR_PC_RESET};
			effAddr_r       <= 12'h000;
			memRdData_r     <= 8'h00;
			memHit_r        <= 1'b0;
			intRequest_r    <= 1'b0;
			intLevel_r      <= 3'h0;
			busy_r          <= 1'b0;
		end else begin
			// code sits at the top of the map, so the counter is offset into it
			nextInstrAddr_r <= {`CPR_CODE_BASE, pc_r};
			// program space starts at the code base, data space at zero
			effAddr_r       <= {(xSpace_r ? `CPR_CODE_BASE : `CPR_DATA_BASE), idxSum};
			busy_r          <= (state_nxt != ST_IDLE);
			memHit_r        <= 1'b0;
			memRdData_r     <= 8'h00;
			if (memRdEn) begin
				if (memAddr == `CPR_ADDR_XHI) begin
					// the space bit is write-only and reads back as zero
					memRdData_r <= {6'h00, xLow_r[9:8]};
					memHit_r    <= 1'b1;
				end else if (memAddr == `CPR_ADDR_XLO) begin
					memRdData_r <= xLow_r[7:0];
					memHit_r    <= 1'b1;
				end else if (memAddr == `CPR_ADDR_STK) begin
					memRdData_r <= {4'h0, stackIndex_r};
					memHit_r    <= 1'b1;
				end else if (memAddr == `CPR_ADDR_FLAGS) begin
					memRdData_r <= flags_r;
					memHit_r    <= 1'b1;
				end
			end
			// pending sources only divert the core while the mask is set
			intRequest_r <= flags_r[`CPR_F_GIE] & (|irqPending);
			if (irqPending[4]) begin
				intLevel_r <= 3'h5;
			end else if (irqPending[3]) begin
				intLevel_r <= 3'h4;
			end else if (irqPending[2]) begin
				intLevel_r <= 3'h3;
			end else if (irqPending[1]) begin
				intLevel_r <= 3'h2;
			end else if (irqPending[0]) begin
				intLevel_r <= 3'h1;
			end else begin
				intLevel_r <= 3'h0;
			end
		end
	end

endmodule

/* bench/cpr_core_regs_sva.sv */
/*
 Checker for the core register block: stack sequences, flags, priority pick.
 Assumes it sees only the block's ports and is attached by the bind below.
*/
`timescale 1ns/1ps
`include "cpr_defines.vh"
module cpr_core_regs_sva (
	// clock and reset
	input wire        clk,
	input wire        rst,
	// requests
	input wire        opValid,
	input wire [4:0]  opCode,
	input wire [7:0]  opData,
	input wire [10:0] opAddr,
	input wire        memWrEn,
	input wire [7:0]  memAddr,
	input wire [7:0]  memWrData,
	input wire [4:0]  irqPending,
	// results
	input wire        stkWrEn_r,
	input wire        stkRdEn_r,
	input wire [7:0]  stkAddr_r,
	input wire [7:0]  stkWrData_r,
	input wire        intRequest_r,
	input wire [2:0]  intLevel_r,
	input wire [7:0]  acc_r,
	input wire [11:0] nextInstrAddr_r,
	input wire [7:0]  flags_r,
	input wire [3:0]  stackIndex_r,
	input wire        busy_r
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	//==============================================================
	// helpers
	// highest pending source, independent of the mask
	function automatic [2:0] topLevel(input [4:0] p);
		topLevel = p[4] ? 3'h5 : p[3] ? 3'h4 : p[2] ? 3'h3 : p[1] ? 3'h2 : p[0] ? 3'h1 : 3'h0;
	endfunction
	// an operation accepted by the idle sequencer port
	sequence taken(logic [4:0] c);
		opValid && !busy_r && opCode == c;
	endsequence
	sequence pushLow;
		stkWrEn_r && stkAddr_r == {4'h3, $past(stackIndex_r)} && {4'h0, stkWrData_r} == ($past(nextInstrAddr_r) & 12'h0FF);
	endsequence
	sequence pullHigh;
		stkRdEn_r && stkAddr_r == {4'h3, $past(stackIndex_r) + 4'h1};
	endsequence

	//==============================================================
	// properties
	AST_CALL_PUSH: assert property (
		taken(`CPR_OP_CALL) |-> ##1 pushLow ##1 (stkWrEn_r && stackIndex_r == $past(stackIndex_r, 2) - 4'h2))
		else $error("call push wrong");
	AST_PULL: assert property (
		(taken(`CPR_OP_RET) or taken(`CPR_OP_INTERRUPT_EXIT)) |-> ##1 pullHigh ##3 (!busy_r && stackIndex_r == $past(stackIndex_r, 4) + 4'h2))
		else $error("pull wrong");
	AST_INTERRUPT_EXIT_G: assert property (
		taken(`CPR_OP_INTERRUPT_EXIT) |-> ##4 flags_r[`CPR_F_GIE])
		else $error("mask not restored");
	AST_SOFTWARE_TRAP: assert property (
		taken(`CPR_OP_SOFTWARE_TRAP) |-> ##2 !flags_r[`CPR_F_GIE] ##1 nextInstrAddr_r == (12'hC00 | ({1'b0, $past(opAddr, 3)} & 12'h3FF)))
		else $error("interrupt entry wrong");
	AST_BUSY_HOLD: assert property (
		busy_r |=> $stable(acc_r))
		else $error("accumulator moved while busy");
	AST_FLAG_STORE: assert property (
		memWrEn && memAddr == `CPR_ADDR_FLAGS && !busy_r && !opValid
		|=> (flags_r & 8'h7F) == (($past(flags_r) & 8'h0F) | ($past(memWrData) & 8'h10)))
		else $error("flags store wrong");
	AST_LOAD_ZN: assert property (
		taken(`CPR_OP_LDA) |=> acc_r == $past(opData) && flags_r[`CPR_F_ZERO] == (acc_r == 8'h00) && flags_r[`CPR_F_NEG] == acc_r[7])
		else $error("load flags wrong");
	AST_PRIORITY: assert property (
		intLevel_r == topLevel($past(irqPending)))
		else $error("priority pick wrong");
	AST_MASK_GATE: assert property (
		intRequest_r == (($past(flags_r) & 8'h10) != 8'h00 && $past(irqPending) != 5'h00))
		else $error("request not gated by mask");
	AST_STACK_WIN: assert property (
		(stkWrEn_r || stkRdEn_r) |-> stkAddr_r[7:4] == 4'h3)
		else $error("stack address outside window");
endmodule

bind cpr_core_regs cpr_core_regs_sva u_sva (.clk(clk), .rst(rst), .opValid(opValid), .opCode(opCode),
	.opData(opData), .opAddr(opAddr), .memWrEn(memWrEn), .memAddr(memAddr), .memWrData(memWrData),
	.irqPending(irqPending), .stkWrEn_r(stkWrEn_r), .stkRdEn_r(stkRdEn_r), .stkAddr_r(stkAddr_r),
	.stkWrData_r(stkWrData_r), .intRequest_r(intRequest_r), .intLevel_r(intLevel_r), .acc_r(acc_r),
	.nextInstrAddr_r(nextInstrAddr_r), .flags_r(flags_r), .stackIndex_r(stackIndex_r), .busy_r(busy_r));

/* bench/cpr_core_regs_test.sv */
/*
 Self-checking bench for the core register block.
 Assumes the block's documented port timing; models the return-stack SRAM.
*/
`timescale 1ns/1ps
`include "cpr_defines.vh"
module cpr_core_regs_test;
	// design inputs
	logic        clk       = 1'b0;
	logic        rst       = 1'b1;
	logic        opValid   = 1'b0;
	logic [4:0]  opCode    = 5'h00;
	logic [7:0]  opData    = 8'h00;
	logic [10:0] opAddr    = 11'h000;
	logic        pcStep    = 1'b0;
	logic [7:0]  idxOffset = 8'h00;
	logic        memWrEn   = 1'b0;
	logic        memRdEn   = 1'b0;
	logic [7:0]  memAddr   = 8'h00;
	logic [7:0]  memWrData = 8'h00;
	logic [7:0]  stkRdData = 8'h00;
	logic [4:0]  irqPending = 5'h00;
	logic        eeReady   = 1'b1;
	// design outputs
	wire  [7:0]  memRdData_r, stkAddr_r, stkWrData_r, acc_r, flags_r;
	wire         memHit_r, stkWrEn_r, stkRdEn_r, intRequest_r, busy_r;
	wire  [2:0]  intLevel_r;
	wire  [3:0]  stackIndex_r;
	wire  [11:0] nextInstrAddr_r, effAddr_r;
	logic [7:0]  ram [0:15];
	int          fails = 0;
	int          n_tests = 0;

	cpr_core_regs dut (.clk(clk), .rst(rst), .opValid(opValid), .opCode(opCode), .opData(opData),
		.opAddr(opAddr), .pcStep(pcStep), .idxOffset(idxOffset), .memWrEn(memWrEn), .memRdEn(memRdEn),
		.memAddr(memAddr), .memWrData(memWrData), .memRdData_r(memRdData_r), .memHit_r(memHit_r),
		.stkWrEn_r(stkWrEn_r), .stkRdEn_r(stkRdEn_r), .stkAddr_r(stkAddr_r), .stkWrData_r(stkWrData_r),
		.stkRdData(stkRdData), .irqPending(irqPending), .eeReady(eeReady), .intRequest_r(intRequest_r),
		.intLevel_r(intLevel_r), .acc_r(acc_r), .nextInstrAddr_r(nextInstrAddr_r), .effAddr_r(effAddr_r),
		.flags_r(flags_r), .stackIndex_r(stackIndex_r), .busy_r(busy_r));

	//==============================================================
	// clock and stack sram
	always #5 clk = ~clk;
	// one-cycle read; between reads the data toggles so stale bytes cannot pass
	always @(posedge clk) begin
		if (stkWrEn_r)
			ram[stkAddr_r[3:0]] <= stkWrData_r;
		stkRdData <= stkRdEn_r ? ram[stkAddr_r[3:0]] : ~stkRdData;
	end

	//==============================================================
	// shared tasks
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// one operation; held until the taking edge
	task automatic op(input logic [4:0] c, input logic [7:0] d, input logic [10:0] a);
		@(posedge clk);
		opValid <= 1'b1;
		opCode <= c;
		opData <= d;
		opAddr <= a;
		@(posedge clk);
		opValid <= 1'b0;
		#1;
	endtask
	task automatic mwr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		memWrEn <= 1'b1;
		memAddr <= a;
		memWrData <= d;
		@(posedge clk);
		memWrEn <= 1'b0;
		#1;
	endtask
	// expected value is {hit, data}
	task automatic mrd(input logic [7:0] a, input logic [11:0] exp);
		@(posedge clk);
		memRdEn <= 1'b1;
		memAddr <= a;
		@(posedge clk);
		memRdEn <= 1'b0;
		#1;
		chk("load", exp, {3'h0, memHit_r, memRdData_r});
	endtask
	task automatic waitEdges(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	//==============================================================
	// scenarios
	task automatic t_reset;
		chk("acc", 12'h000, {4'h0, acc_r});
		chk("pc", 12'hC00, nextInstrAddr_r);
		mrd(`CPR_ADDR_STK, 12'h10F);
		mrd(`CPR_ADDR_FLAGS, 12'h180);
		mrd(8'h50, 12'h000);
	endtask
	task automatic t_alu;
		op(`CPR_OP_LDA, 8'h80, 11'h000);
		chk("flags", 12'h081, {4'h0, flags_r});
		op(`CPR_OP_CLR, 8'h00, 11'h000);
		chk("flags", 12'h088, {4'h0, flags_r});
		op(`CPR_OP_LDA, 8'h0F, 11'h000);
		op(`CPR_OP_ADD, 8'h01, 11'h000);
		chk("flags", 12'h082, {4'h0, flags_r});
		op(`CPR_OP_ADD, 8'hF0, 11'h000);
		chk("flags", 12'h08C, {4'h0, flags_r});
		op(`CPR_OP_RC, 8'h00, 11'h000);
		chk("flags", 12'h088, {4'h0, flags_r});
		op(`CPR_OP_SC, 8'h00, 11'h000);
		chk("flags", 12'h08E, {4'h0, flags_r});
		op(`CPR_OP_CARRY_INVERT, 8'h00, 11'h000);
		chk("carry", 12'h000, {11'h0, flags_r[`CPR_F_CARRY]});
		op(`CPR_OP_LDC, 8'h01, 11'h000);
		chk("carry", 12'h001, {11'h0, flags_r[`CPR_F_CARRY]});
		op(`CPR_OP_LDA, 8'h81, 11'h000);
		op(`CPR_OP_RLC, 8'h00, 11'h000);
		chk("acc", 12'h003, {4'h0, acc_r});
		op(`CPR_OP_RRC, 8'h00, 11'h000);
		chk("acc", 12'h081, {4'h0, acc_r});
		op(`CPR_OP_LDA, 8'h00, 11'h000);
		op(`CPR_OP_SUBC, 8'h01, 11'h000);
		chk("acc", 12'h0FF, {4'h0, acc_r});
		chk("carry", 12'h000, {11'h0, flags_r[`CPR_F_CARRY]});
		// the remaining accumulator ops; flags checked after INC, DEC and ADDC, the result after AND, OR and XOR
		op(`CPR_OP_INC, 8'h00, 11'h000);
		chk("flags", 12'h088, {4'h0, flags_r});
		op(`CPR_OP_DEC, 8'h00, 11'h000);
		chk("flags", 12'h081, {4'h0, flags_r});
		op(`CPR_OP_AND, 8'h0F, 11'h000);
		chk("acc", 12'h00F, {4'h0, acc_r});
		op(`CPR_OP_OR, 8'hF0, 11'h000);
		chk("acc", 12'h0FF, {4'h0, acc_r});
		op(`CPR_OP_XOR, 8'h0F, 11'h000);
		chk("acc", 12'h0F0, {4'h0, acc_r});
		op(`CPR_OP_SC, 8'h00, 11'h000);
		op(`CPR_OP_ADDC, 8'h0F, 11'h000);
		chk("flags", 12'h08E, {4'h0, flags_r});
	endtask
	task automatic t_flags;
		op(`CPR_OP_CLR, 8'h00, 11'h000);
		op(`CPR_OP_SC, 8'h00, 11'h000);
		@(posedge clk);
		eeReady <= 1'b0;
		waitEdges(2);
		chk("flags", 12'h00E, {4'h0, flags_r});
		mwr(`CPR_ADDR_FLAGS, 8'hFF);
		mrd(`CPR_ADDR_FLAGS, 12'h11E);
		mwr(`CPR_ADDR_FLAGS, 8'h00);
		chk("flags", 12'h00E, {4'h0, flags_r});
		op(`CPR_OP_SETG, 8'h00, 11'h000);
		chk("flags", 12'h01E, {4'h0, flags_r});
		@(posedge clk);
		eeReady <= 1'b1;
	endtask
	task automatic t_index;
		@(posedge clk);
		idxOffset <= 8'h05;
		mwr(`CPR_ADDR_XHI, 8'hFB);
		mwr(`CPR_ADDR_XLO, 8'h10);
		waitEdges(2);
		chk("eff", 12'h315, effAddr_r);
		mrd(`CPR_ADDR_XHI, 12'h103);
		mrd(`CPR_ADDR_XLO, 12'h110);
		mwr(`CPR_ADDR_XHI, 8'h07);
		waitEdges(2);
		chk("eff", 12'hF15, effAddr_r);
		mrd(`CPR_ADDR_XHI, 12'h103);
		op(`CPR_OP_LDX, 8'h00, 11'h405);
		waitEdges(2);
		chk("eff", 12'hC0A, effAddr_r);
	endtask
	task automatic t_call;
		op(`CPR_OP_JMP, 8'h00, 11'h123);
		// the visible address trails the counter by one edge
		waitEdges(1);
		chk("pc", 12'hD23, nextInstrAddr_r);
		@(posedge clk);
		pcStep <= 1'b1;
		@(posedge clk);
		pcStep <= 1'b0;
		op(`CPR_OP_CALL, 8'h00, 11'h200);
		waitEdges(2);
		chk("pc", 12'hE00, nextInstrAddr_r);
		chk("sp", 12'h00D, {8'h00, stackIndex_r});
		chk("low byte", 12'h024, {4'h0, ram[15]});
		chk("high byte", 12'h001, {4'h0, ram[14]});
		op(`CPR_OP_RET, 8'h00, 11'h000);
		waitEdges(4);
		chk("pc", 12'hD24, nextInstrAddr_r);
		chk("sp", 12'h00F, {8'h00, stackIndex_r});
	endtask
	task automatic t_irq;
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			irqPending <= (5'h01 << i) | ((5'h01 << i) - 5'h01);
			waitEdges(2);
			chk("level", 12'(i + 1), {9'h0, intLevel_r});
			chk("request", 12'h001, {11'h0, intRequest_r});
		end
		mwr(`CPR_ADDR_FLAGS, 8'h00);
		waitEdges(2);
		chk("request", 12'h000, {11'h0, intRequest_r});
		@(posedge clk);
		irqPending <= 5'h00;
		mwr(`CPR_ADDR_FLAGS, 8'h10);
		op(`CPR_OP_SOFTWARE_TRAP, 8'h00, 11'h040);
		waitEdges(2);
		chk("mask", 12'h000, {11'h0, flags_r[`CPR_F_GIE]});
		chk("pc", 12'hC40, nextInstrAddr_r);
		op(`CPR_OP_INTERRUPT_EXIT, 8'h00, 11'h000);
		waitEdges(4);
		chk("mask", 12'h001, {11'h0, flags_r[`CPR_F_GIE]});
		chk("pc", 12'hD24, nextInstrAddr_r);
	endtask

	//==============================================================
	// run control
	task automatic complete_run;
		$display("fails=%0d n_tests=%0d", fails, n_tests);
		if (fails == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// the whole sequence needs about 140 cycles
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		complete_run();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		waitEdges(1);
		t_reset();
		t_alu();
		t_flags();
		t_index();
		t_call();
		t_irq();
		complete_run();
	end
endmodule
